// file: pkg/stepper_pkg.sv
// Shared constants for the two-channel stepper bridge control block.
// Assumes a single 10 MHz clock and a simple strobe register port.
package stepper_pkg;

  // ****************************************
  // Register port geometry
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int SYNC_STAGES = 2;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CHOP_PERIOD = 8'h10;

  // ****************************************
  // Interrupt event bits
  // ****************************************
  localparam int IRQ_W = 4;
  localparam int IRQ_THERMAL = 0;
  localparam int IRQ_OVERCUR = 1;
  localparam int IRQ_SUPPLY_LOST = 2;
  localparam int IRQ_STANDBY_EXIT = 3;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 4'h0;

  // ****************************************
  // State register bits
  // ****************************************
  localparam int ST_THERMAL = 0;
  localparam int ST_OVERCUR = 1;
  localparam int ST_SUPPLY_OK = 2;
  localparam int ST_STANDBY = 3;
  localparam int ST_DRIVE_A = 4;
  localparam int ST_DRIVE_B = 5;
  localparam int ST_OSC_RUN = 6;
  localparam int ST_MODE_LSB = 8;

  // ****************************************
  // Target current in percent of full scale
  // ****************************************
  localparam int PCT_W = 7;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
  localparam logic [PCT_W-1:0] PCT_HIGH = 7'h47;
  localparam logic [PCT_W-1:0] PCT_LOW = 7'h26;
  localparam logic [PCT_W-1:0] PCT_ZERO = 7'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int CHOP_FREQ_KHZ = 100;
  localparam logic [DATA_W-1:0] CHOP_PERIOD_RST = DATA_W'(CLK_FREQ_KHZ / CHOP_FREQ_KHZ);
  localparam logic [DATA_W-1:0] CHOP_PERIOD_MIN = 16'h0002;

  typedef enum logic [1:0] {
    MODE_POR,
    MODE_STANDBY,
    MODE_RUN,
    MODE_FAULT
  } mode_t;

endpackage

// file: rtl/input_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are quasi-static levels; no bus coherency is given.
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic clk_en, // Freezes the stages while low
  input wire logic [WIDTH-1:0] async_in, // Pins from outside the clock domain
  output logic [WIDTH-1:0] sync_out // Levels safe to decode
);
  logic [WIDTH-1:0] meta_reg;

  // ****************************************
  // Capture stages
  // ****************************************
  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: rtl/stepper_bridge_control.sv
// Control logic of a two-channel bipolar stepper bridge driver.
// Assumes host-driven async logic pins, analog trip comparators and supply monitors
// as level inputs, and a strobe register port on the core clock.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Both level bits high give 100, only the first 71, only the second 38 percent, signed by direction.
// - Both level bits low put that channel's bridge in high impedance with zero current.
// - Direction high drives positive side high and negative low; low reverses the drive.
// - Standby low stops the chopping oscillator and turns every output off.
// - A thermal trip turns all outputs off and latches that fault.
// - The thermal latch clears only on power restart or a standby high-low-high sequence.
// - Outputs stay forced off until both motor and logic supply monitors report valid.
// - An over-current trip resets the drive, forces outputs off and latches that state.
// - The over-current latch clears only on a standby high-low-high sequence or power restart.
// - While the over-current latch is set the block behaves as in standby.
module stepper_bridge_control
  import stepper_pkg::*;
#(
  parameter logic [DATA_W-1:0] CHOP_PERIOD_DEFAULT = CHOP_PERIOD_RST
) (
  input wire logic clk, // Core clock, 10 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic level_a_bit1, // Channel A level bit 1 pin
  input wire logic level_a_bit2, // Channel A level bit 2 pin
  input wire logic level_b_bit1, // Channel B level bit 1 pin
  input wire logic level_b_bit2, // Channel B level bit 2 pin
  input wire logic dir_a, // Channel A current direction pin
  input wire logic dir_b, // Channel B current direction pin
  input wire logic standby, // High: run, low: stop
  input wire logic thermal_trip, // Junction temperature comparator
  input wire logic overcurrent_trip, // Output current comparator
  input wire logic motor_supply_ok, // Motor supply monitor
  input wire logic logic_supply_ok, // Logic supply monitor
  input wire logic [stepper_pkg::ADDR_W-1:0] reg_addr, // Register address
  input wire logic [stepper_pkg::DATA_W-1:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [stepper_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
  output logic bridge_a_pos, // Channel A positive output level
  output logic bridge_a_pos_oe, // Channel A positive output driven
  output logic bridge_a_neg, // Channel A negative output level
  output logic bridge_a_neg_oe, // Channel A negative output driven
  output logic bridge_b_pos, // Channel B positive output level
  output logic bridge_b_pos_oe, // Channel B positive output driven
  output logic bridge_b_neg, // Channel B negative output level
  output logic bridge_b_neg_oe, // Channel B negative output driven
  output logic [stepper_pkg::PCT_W-1:0] current_a_pct, // Channel A target magnitude
  output logic current_a_neg, // Channel A target sign, high for minus
  output logic [stepper_pkg::PCT_W-1:0] current_b_pct, // Channel B target magnitude
  output logic current_b_neg, // Channel B target sign, high for minus
  output logic chop_osc_run, // Chopping oscillator running
  output logic chop_tick, // One-cycle pulse per chopping period
  output logic irq // Level interrupt
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [PCT_W-1:0] level_pct(input logic bit1, input logic bit2);
    logic [PCT_W-1:0] pct;
    pct = PCT_ZERO;
    if (bit1 && bit2) begin
      pct = PCT_FULL;
    end else if (bit1) begin
      pct = PCT_HIGH;
    end else if (bit2) begin
      pct = PCT_LOW;
    end
    return pct;
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // ****************************************
  // Input synchronisation
  // ****************************************
  localparam int N_SYNC = 10;
  logic [N_SYNC-1:0] pins_async;
  logic [N_SYNC-1:0] pins_sync;
  logic la1_s;
  logic la2_s;
  logic lb1_s;
  logic lb2_s;
  logic dira_s;
  logic dirb_s;
  logic standby_s;
  logic thermal_s;
  logic overcur_s;
  logic supplies_s;

  assign pins_async = {logic_supply_ok & motor_supply_ok, overcurrent_trip, thermal_trip,
                       standby, dir_b, dir_a, level_b_bit2, level_b_bit1,
                       level_a_bit2, level_a_bit1};

  input_sync #(
    .WIDTH(N_SYNC)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  assign {supplies_s, overcur_s, thermal_s, standby_s, dirb_s, dira_s,
          lb2_s, lb1_s, la2_s, la1_s} = pins_sync;

  // ****************************************
  // Standby edge detection
  // ****************************************
  logic standby_q_reg;
  logic standby_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      standby_q_reg <= 1'b0;
    end else if (clk_en) begin
      standby_q_reg <= standby_s;
    end
  end

  // High to low to high completes on this rising edge
  assign standby_rise = standby_s && !standby_q_reg;

  // ****************************************
  // Fault latches
  // ****************************************
  logic thermal_fault_latch;
  logic overcurrent_fault_latch;

  // A trip in the same cycle as a clearing edge keeps the latch set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      thermal_fault_latch <= 1'b0;
    end else if (clk_en) begin
      if (!supplies_s) begin
        thermal_fault_latch <= 1'b0;
      end else if (thermal_s) begin
        thermal_fault_latch <= 1'b1;
      end else if (standby_rise) begin
        thermal_fault_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overcurrent_fault_latch <= 1'b0;
    end else if (clk_en) begin
      if (!supplies_s) begin
        overcurrent_fault_latch <= 1'b0;
      end else if (overcur_s) begin
        overcurrent_fault_latch <= 1'b1;
      end else if (standby_rise) begin
        overcurrent_fault_latch <= 1'b0;
      end
    end
  end

  // ****************************************
  // Operating mode
  // ****************************************
  mode_t mode_reg;
  mode_t mode_next;
  logic any_fault;

  assign any_fault = thermal_fault_latch || overcurrent_fault_latch || thermal_s || overcur_s;

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_POR: begin
        if (supplies_s) begin
          mode_next = MODE_STANDBY;
        end
      end
      MODE_STANDBY: begin
        if (standby_s && !any_fault) begin
          mode_next = MODE_RUN;
        end
      end
      MODE_RUN: begin
        if (any_fault) begin
          mode_next = MODE_FAULT;
        end else if (!standby_s) begin
          mode_next = MODE_STANDBY;
        end
      end
      MODE_FAULT: begin
        if (!standby_s) begin
          mode_next = MODE_STANDBY;
        end
      end
      default: begin
        mode_next = MODE_POR;
      end
    endcase
    if (!supplies_s) begin
      mode_next = MODE_POR;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_reg <= MODE_POR;
    end else if (clk_en) begin
      mode_reg <= mode_next;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [DATA_W-1:0] chop_osc_set;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_enable_reg;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clear;
  logic [DATA_W-1:0] state_word;
  logic [DATA_W-1:0] rdata_next;
  logic drive_ok;

  // Periods below the minimum would stall the divider, so they are clamped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chop_osc_set <= CHOP_PERIOD_DEFAULT;
    end else if (clk_en && reg_wr && addr_hit(reg_addr, OFS_CHOP_PERIOD)) begin
      if (reg_wdata < CHOP_PERIOD_MIN) begin
        chop_osc_set <= CHOP_PERIOD_MIN;
      end else begin
        chop_osc_set <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_enable_reg <= IRQ_ENABLE_RST;
    end else if (clk_en && reg_wr && addr_hit(reg_addr, OFS_IRQ_ENABLE)) begin
      irq_enable_reg <= reg_wdata[IRQ_W-1:0];
    end
  end

  assign irq_clear = (reg_wr && addr_hit(reg_addr, OFS_IRQ_CLEAR)) ?
                     reg_wdata[IRQ_W-1:0] : '0;

  always_comb begin
    irq_events = '0;
    irq_events[IRQ_THERMAL] = thermal_s && !thermal_fault_latch && supplies_s;
    irq_events[IRQ_OVERCUR] = overcur_s && !overcurrent_fault_latch && supplies_s;
    irq_events[IRQ_SUPPLY_LOST] = (mode_reg != MODE_POR) && !supplies_s;
    irq_events[IRQ_STANDBY_EXIT] = standby_rise;
  end

  // New events win over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
    end else if (clk_en) begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  assign drive_ok = (mode_reg == MODE_RUN) && !any_fault && standby_s && supplies_s;

  always_comb begin
    state_word = '0;
    state_word[ST_THERMAL] = thermal_fault_latch;
    state_word[ST_OVERCUR] = overcurrent_fault_latch;
    state_word[ST_SUPPLY_OK] = supplies_s;
    state_word[ST_STANDBY] = standby_s;
    state_word[ST_DRIVE_A] = bridge_a_pos_oe;
    state_word[ST_DRIVE_B] = bridge_b_pos_oe;
    state_word[ST_OSC_RUN] = chop_osc_run;
    state_word[ST_MODE_LSB +: 2] = mode_reg;
  end

  // Unmapped and write-only addresses read as zero
  always_comb begin
    rdata_next = '0;
    if (addr_hit(reg_addr, OFS_STATE)) begin
      rdata_next = state_word;
    end else if (addr_hit(reg_addr, OFS_IRQ_STATUS)) begin
      rdata_next[IRQ_W-1:0] = irq_status_reg;
    end else if (addr_hit(reg_addr, OFS_IRQ_ENABLE)) begin
      rdata_next[IRQ_W-1:0] = irq_enable_reg;
    end else if (addr_hit(reg_addr, OFS_CHOP_PERIOD)) begin
      rdata_next = chop_osc_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_next : '0;
    end
  end

  // ****************************************
  // Chopping oscillator
  // ****************************************
  logic [DATA_W-1:0] chop_cnt_reg;
  logic osc_allowed;

  // Thermal fault only blanks the bridge; standby and over-current stop the oscillator
  assign osc_allowed = standby_s && supplies_s && !overcurrent_fault_latch && !overcur_s &&
                       (mode_reg != MODE_POR) && (mode_reg != MODE_STANDBY || standby_s);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chop_cnt_reg <= '0;
      chop_tick <= 1'b0;
      chop_osc_run <= 1'b0;
    end else if (clk_en) begin
      chop_osc_run <= osc_allowed;
      chop_tick <= 1'b0;
      if (!osc_allowed) begin
        chop_cnt_reg <= '0;
      end else if (chop_cnt_reg >= chop_osc_set - 16'h0001) begin
        chop_cnt_reg <= '0;
        chop_tick <= 1'b1;
      end else begin
        chop_cnt_reg <= chop_cnt_reg + 16'h0001;
      end
    end
  end

  // ****************************************
  // Bridge decode
  // ****************************************
  logic [PCT_W-1:0] pct_a;
  logic [PCT_W-1:0] pct_b;
  logic en_a;
  logic en_b;

  // Direction and level are only trusted once the motor supply is valid
  assign pct_a = drive_ok ? level_pct(la1_s, la2_s) : PCT_ZERO;
  assign pct_b = drive_ok ? level_pct(lb1_s, lb2_s) : PCT_ZERO;
  assign en_a = pct_a != PCT_ZERO;
  assign en_b = pct_b != PCT_ZERO;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bridge_a_pos <= 1'b0;
      bridge_a_neg <= 1'b0;
      bridge_a_pos_oe <= 1'b0;
      bridge_a_neg_oe <= 1'b0;
      current_a_pct <= PCT_ZERO;
      current_a_neg <= 1'b0;
    end else if (clk_en) begin
      bridge_a_pos_oe <= en_a;
      bridge_a_neg_oe <= en_a;
      bridge_a_pos <= en_a && dira_s;
      bridge_a_neg <= en_a && !dira_s;
      current_a_pct <= pct_a;
      current_a_neg <= en_a && !dira_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bridge_b_pos <= 1'b0;
      bridge_b_neg <= 1'b0;
      bridge_b_pos_oe <= 1'b0;
      bridge_b_neg_oe <= 1'b0;
      current_b_pct <= PCT_ZERO;
      current_b_neg <= 1'b0;
    end else if (clk_en) begin
      bridge_b_pos_oe <= en_b;
      bridge_b_neg_oe <= en_b;
      bridge_b_pos <= en_b && dirb_s;
      bridge_b_neg <= en_b && !dirb_s;
      current_b_pct <= pct_b;
      current_b_neg <= en_b && !dirb_s;
    end
  end

endmodule
`default_nettype wire

// file: verification/host_pin_model.sv
// Host controller model driving the level, direction and standby pins.
// Assumes the bench commands it through want and want_stby on the core clock.
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
  input wire logic clk, // Core clock
  input wire logic motor_supply_ok, // Motor supply as the host sees it
  input wire logic [5:0] want, // Wanted {dir_a, a1, a2, dir_b, b1, b2}
  input wire logic want_stby, // Wanted standby level
  output logic [5:0] pins = 6'h00, // Driven {dir_a, a1, a2, dir_b, b1, b2}
  output logic standby = 1'b0 // Standby pin
);
  // Pins stay low until the motor supply is up, so no drive meets a dead bridge
  always @(posedge clk) begin
    pins <= motor_supply_ok ? want : 6'h00;
  end
  // Latches are cleared by walking standby high, low, high
  always @(posedge clk) begin
    standby <= want_stby;
  end
endmodule
`default_nettype wire

// file: verification/stepper_bridge_chk.sv
// Concurrent checks on the ports of the stepper bridge control block.
// Assumes clk_en stays high, so every latency below is in plain clock cycles.
`timescale 1ns/1ps
`default_nettype none
module stepper_bridge_chk
  import stepper_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic level_a_bit1, // Channel A level bit 1
  input wire logic level_a_bit2, // Channel A level bit 2
  input wire logic dir_a, // Channel A direction
  input wire logic standby, // Run when high
  input wire logic thermal_trip, // Over temperature
  input wire logic overcurrent_trip, // Over current
  input wire logic motor_supply_ok, // Motor supply valid
  input wire logic logic_supply_ok, // Logic supply valid
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [stepper_pkg::DATA_W-1:0] reg_rdata, // Read data
  input wire logic bridge_a_pos, // Channel A positive level
  input wire logic bridge_a_neg, // Channel A negative level
  input wire logic bridge_a_pos_oe, // Channel A positive driven
  input wire logic bridge_a_neg_oe, // Channel A negative driven
  input wire logic bridge_b_pos_oe, // Channel B positive driven
  input wire logic bridge_b_neg_oe, // Channel B negative driven
  input wire logic [stepper_pkg::PCT_W-1:0] current_a_pct, // Channel A magnitude
  input wire logic current_a_neg, // Channel A sign
  input wire logic chop_osc_run, // Oscillator running
  input wire logic chop_tick, // Chop pulse
  input wire logic irq // Interrupt
);
  logic sup;
  logic all_off;
  assign sup = motor_supply_ok && logic_supply_ok;
  assign all_off = !(bridge_a_pos_oe || bridge_a_neg_oe || bridge_b_pos_oe || bridge_b_neg_oe);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Pins pass two flops and one output register, hence the repeat counts
  // ****************************************
  a_por_off: assert property ((!sup)[*5] |-> all_off && current_a_pct == PCT_ZERO)
    else $error("outputs driven without valid supplies");
  a_standby_off: assert property ((!standby)[*5] |-> all_off && !chop_osc_run)
    else $error("outputs or oscillator active in standby");
  a_zero_hiz: assert property ((!level_a_bit1 && !level_a_bit2)[*4] |->
    !bridge_a_pos_oe && !bridge_a_neg_oe && current_a_pct == PCT_ZERO)
    else $error("channel A driven with zero level");
  a_level_pct: assert property ((level_a_bit1 && !level_a_bit2)[*4] ##0 bridge_a_pos_oe |->
    current_a_pct == PCT_HIGH)
    else $error("channel A magnitude wrong for level 10");
  a_dir_drive: assert property (dir_a[*4] ##0 bridge_a_pos_oe |->
    bridge_a_pos && !bridge_a_neg && !current_a_neg)
    else $error("channel A polarity wrong for direction high");
  a_thermal_off: assert property (thermal_trip[*5] |-> all_off)
    else $error("outputs driven during thermal trip");
  a_thermal_hold: assert property ((standby && sup)[*3] ##0 thermal_trip ##1
    (!thermal_trip && standby && sup)[*8] |-> all_off)
    else $error("thermal latch released without standby cycle");
  a_ocp_stop: assert property (overcurrent_trip[*5] |-> all_off && !chop_osc_run)
    else $error("over-current did not stop the block");
  a_ocp_hold: assert property ((standby && sup)[*3] ##0 overcurrent_trip ##1
    (!overcurrent_trip && standby && sup)[*8] |-> !chop_osc_run && all_off)
    else $error("over-current latch released without standby cycle");
  a_sync_delay: assert property ((!dir_a)[*4] ##1 dir_a[*3] |-> !bridge_a_pos)
    else $error("direction change seen before two sync stages");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  a_irq_fall: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("interrupt dropped without a register write");
  a_tick_pulse: assert property (chop_tick |=> !chop_tick)
    else $error("chop tick longer than one cycle");
  c_thermal: cover property (thermal_trip ##1 !thermal_trip);
  c_ocp: cover property (overcurrent_trip ##1 !overcurrent_trip);
  c_irq: cover property ($rose(irq));
endmodule
bind stepper_bridge_control stepper_bridge_chk chk_u (.clk, .rst_n, .level_a_bit1, .level_a_bit2,
  .dir_a, .standby, .thermal_trip, .overcurrent_trip, .motor_supply_ok, .logic_supply_ok,
  .reg_wr, .reg_rd, .reg_rdata, .bridge_a_pos, .bridge_a_neg, .bridge_a_pos_oe, .bridge_a_neg_oe,
  .bridge_b_pos_oe, .bridge_b_neg_oe, .current_a_pct, .current_a_neg, .chop_osc_run,
  .chop_tick, .irq);
`default_nettype wire

// file: verification/test_stepper_bridge_control.sv
// Self-checking bench for the stepper bridge control block.
// Assumes the host pin model in front and the checker bound to the design.
`timescale 1ns/1ps
`default_nettype none
module test_stepper_bridge_control;
  import stepper_pkg::*;
  localparam logic [DATA_W-1:0] PER = 16'h0004;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic thermal_trip = 1'b0;
  logic overcurrent_trip = 1'b0;
  logic motor_supply_ok = 1'b0;
  logic logic_supply_ok = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic snap = 1'b0;
  logic rd_pend = 1'b0;
  logic want_stby = 1'b0;
  logic [5:0] want = 6'h00;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 16'h0000;
  logic [DATA_W-1:0] reg_rdata;
  logic [5:0] pins;
  logic standby;
  logic a_p, a_po, a_n, a_no, b_p, b_po, b_n, b_no, na, nb, osc, irq;
  logic [PCT_W-1:0] pa, pb;
  logic [25:0] obs;
  logic [31:0] q[$];
  int bad_count = 0;
  int checked = 0;

  always #50 clk = ~clk;

  host_pin_model host_u (.clk(clk), .motor_supply_ok(motor_supply_ok), .want(want),
    .want_stby(want_stby), .pins(pins), .standby(standby));
  stepper_bridge_control #(.CHOP_PERIOD_DEFAULT(PER)) dut_u (.clk(clk), .rst_n(rst_n),
    .clk_en(1'b1), .level_a_bit1(pins[4]), .level_a_bit2(pins[3]), .level_b_bit1(pins[1]),
    .level_b_bit2(pins[0]), .dir_a(pins[5]), .dir_b(pins[2]), .standby(standby),
    .thermal_trip(thermal_trip), .overcurrent_trip(overcurrent_trip),
    .motor_supply_ok(motor_supply_ok), .logic_supply_ok(logic_supply_ok), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bridge_a_pos(a_p), .bridge_a_pos_oe(a_po), .bridge_a_neg(a_n), .bridge_a_neg_oe(a_no),
    .bridge_b_pos(b_p), .bridge_b_pos_oe(b_po), .bridge_b_neg(b_n), .bridge_b_neg_oe(b_no),
    .current_a_pct(pa), .current_a_neg(na), .current_b_pct(pb), .current_b_neg(nb),
    .chop_osc_run(osc), .chop_tick(), .irq(irq));

  // Levels are masked by the enables: an undriven bridge has no level worth comparing
  assign obs = {a_po, a_no, a_p & a_po, a_n & a_no, na, pa, b_po, b_no, b_p & b_po, b_n & b_no,
    nb, pb, osc, irq};

  // ****************************************
  // Expectations and checks
  // ****************************************
  function automatic logic [11:0] chan(input logic run, input logic dir, input logic b1,
    input logic b2);
    logic [PCT_W-1:0] p;
    p = b1 ? (b2 ? PCT_FULL : PCT_HIGH) : (b2 ? PCT_LOW : PCT_ZERO);
    return (run && (b1 || b2)) ? {2'b11, dir, !dir, !dir, p} : 12'h000;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  always @(posedge clk) begin
    rd_pend <= reg_rd;
    if (rd_pend) begin
      check({16'h0000, reg_rdata}, q.pop_front());
    end
    if (snap) begin
      check({6'h00, obs}, q.pop_front());
    end
  end

  task automatic settle(input logic run, input logic osc_on, input logic irq_on);
    repeat (12) @(posedge clk);
    q.push_back({6'h00, chan(run, want[5], want[4], want[3]), chan(run, want[2], want[1], want[0]),
      osc_on, irq_on});
    snap <= 1'b1;
    @(posedge clk);
    snap <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    q.push_back({16'h0000, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Trips are held long enough to pass the synchronisers with margin
  task automatic trip(input logic heat);
    @(posedge clk);
    thermal_trip <= heat;
    overcurrent_trip <= !heat;
    repeat (6) @(posedge clk);
    thermal_trip <= 1'b0;
    overcurrent_trip <= 1'b0;
  endtask

  task automatic cycle_standby();
    want_stby <= 1'b0;
    repeat (8) @(posedge clk);
    want_stby <= 1'b1;
  endtask

  task automatic test_done();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int i;
    void'($urandom(91030));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    want <= 6'h3F;
    want_stby <= 1'b1;
    settle(1'b0, 1'b0, 1'b0);
    $display("test power_on done");
    motor_supply_ok <= 1'b1;
    logic_supply_ok <= 1'b1;
    rd(OFS_IRQ_ENABLE, 16'h0000);
    rd(OFS_CHOP_PERIOD, PER);
    wr(OFS_CHOP_PERIOD, 16'h0001);
    rd(OFS_CHOP_PERIOD, CHOP_PERIOD_MIN);
    wr(OFS_CHOP_PERIOD, PER);
    wr(OFS_IRQ_ENABLE, 16'h000F);
    rd(OFS_IRQ_ENABLE, 16'h000F);
    rd(OFS_IRQ_CLEAR, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(OFS_IRQ_ENABLE, 16'h0000);
    $display("test registers done");
    for (i = 0; i < 16; i++) begin
      want <= (i < 8) ? {i[2:0], ~i[2:0]} : 6'($urandom);
      settle(1'b1, 1'b1, 1'b0);
    end
    $display("test decode done");
    want_stby <= 1'b0;
    settle(1'b0, 1'b0, 1'b0);
    want_stby <= 1'b1;
    settle(1'b1, 1'b1, 1'b0);
    $display("test standby done");
    wr(OFS_IRQ_CLEAR, 16'h000F);
    wr(OFS_IRQ_ENABLE, 16'h0001);
    trip(1'b1);
    settle(1'b0, 1'b1, 1'b1);
    rd(OFS_IRQ_STATUS, 16'h0001);
    wr(OFS_IRQ_CLEAR, 16'h0001);
    settle(1'b0, 1'b1, 1'b0);
    cycle_standby();
    settle(1'b1, 1'b1, 1'b0);
    $display("test thermal done");
    trip(1'b0);
    settle(1'b0, 1'b0, 1'b0);
    cycle_standby();
    settle(1'b1, 1'b1, 1'b0);
    $display("test overcurrent done");
    trip(1'b1);
    settle(1'b0, 1'b1, 1'b1);
    logic_supply_ok <= 1'b0;
    settle(1'b0, 1'b0, 1'b1);
    logic_supply_ok <= 1'b1;
    settle(1'b1, 1'b1, 1'b1);
    rd(OFS_IRQ_STATUS, 16'h000F);
    wr(OFS_IRQ_CLEAR, 16'h000F);
    settle(1'b1, 1'b1, 1'b0);
    rd(OFS_STATE, {6'h00, 2'b10, 2'b01, want[1] | want[0], want[4] | want[3], 4'hC});
    $display("test supply_restart done");
    for (i = 0; i < 50 && q.size() != 0; i++) begin
      @(posedge clk);
    end
    if (q.size() != 0) begin
      bad_count++;
    end
    test_done();
  end
endmodule
`default_nettype wire
